/* File: rtl/cptd_pkg.sv */
/*
  Shared constants for the proprietary template decoder: tags, lengths,
  register offsets, field positions and reset values.
  Assumes a single 100 MHz synchronous clock domain.
*/
package cptd_pkg;

  // ==========================================================
  // Tags and fixed lengths
  localparam logic [7:0] TAG_TEMPLATE = 8'ha5;
  localparam logic [7:0] TAG_CHAR     = 8'h80;
  localparam logic [7:0] TAG_POWER    = 8'h81;
  localparam logic [7:0] TAG_MINCLK   = 8'h82;
  localparam logic [7:0] TAG_MEMORY   = 8'h83;
  localparam logic [7:0] LEN_CHAR     = 8'h01;
  localparam logic [7:0] LEN_POWER    = 8'h03;
  localparam logic [7:0] LEN_MINCLK   = 8'h01;
  localparam logic [7:0] LEN_MEM_MIN  = 8'h02;

  // ==========================================================
  // Value codes, frequencies in 0.1 MHz steps
  localparam logic [7:0] FREQ_NONE    = 8'hff;
  localparam logic [7:0] FREQ_MIN     = 8'h0a;
  localparam logic [7:0] PWR_IGNORE0  = 8'h00;
  localparam logic [7:0] PWR_IGNORE1  = 8'hff;
  localparam logic [7:0] PWR_MAX      = 8'h3c;

  // ==========================================================
  // Characteristics byte fields
  localparam int CHAR_STOP_BIT  = 0;
  localparam int CHAR_RSV_LO    = 1;
  localparam int CHAR_HIGH_BIT  = 2;
  localparam int CHAR_LOW_BIT   = 3;
  localparam int CHAR_CLASS_LSB = 4;
  localparam int CHAR_RSV_HI    = 7;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CHAR    = 8'h08;
  localparam logic [7:0] OFS_MEMORY  = 8'h0c;
  localparam logic [7:0] OFS_COUNTS  = 8'h10;
  localparam logic [7:0] OFS_SELECT  = 8'h14;
  localparam logic [7:0] OFS_PWR_DAT = 8'h18;
  localparam logic [7:0] OFS_MIN_DAT = 8'h1c;

  // CTRL fields
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_KIND_LSB    = 1;
  localparam int CTRL_RESTART_BIT = 3;

  // Reset values and store depth
  localparam logic       RST_RUN  = 1'b0;
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam int         STORE_DEPTH = 4;

  typedef enum logic [1:0] {
    KIND_ROOT_MASTER_FILE,
    KIND_DIRECTORY_FILE,
    KIND_APPLICATION_DIRECTORY,
    KIND_ELEMENTARY_FILE
  } cptd_kind_e;

endpackage

/* File: rtl/cptd_strm_if.sv */
/*
  Byte stream carrier between the input buffer and the parser.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ns
interface cptd_strm_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: rtl/cptd_skid.sv */
/*
  Two-entry buffer in the card byte path.
  Assumes upstream data on sys_clk; ready is registered.
*/
`timescale 1ns/1ns
module cptd_skid (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  cptd_strm_if.src        out
);
  logic [7:0] e0_ff;
  logic [7:0] e1_ff;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic       in_ready_ff;
  logic       push;
  logic       pop;

  assign push      = in_valid && in_ready_ff;
  assign pop       = out.valid && out.ready;
  assign out.valid = (cnt_ff != 2'h0);
  assign out.data  = e0_ff;
  assign in_ready  = in_ready_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_ff      <= 2'h0;
      in_ready_ff <= 1'b0;
    end else begin
      cnt_ff      <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != 2'h2);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      e0_ff <= 8'h00;
      e1_ff <= 8'h00;
    end else if (push && pop) begin
      if (cnt_ff == 2'h1) begin
        e0_ff <= in_data;
      end else begin
        e0_ff <= e1_ff;
        e1_ff <= in_data;
      end
    end else if (push) begin
      if (cnt_ff == 2'h0) begin
        e0_ff <= in_data;
      end else begin
        e1_ff <= in_data;
      end
    end else if (pop) begin
      e0_ff <= e1_ff;
    end
  end

  skid_full_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cnt_ff == 2'h2) |-> !in_ready_ff) else $error("buffer full but ready");
endmodule

/* File: rtl/cptd_store.sv */
/*
  Ordered store of repeated template entries, kept in arrival order.
  Assumes writes and clears on sys_clk; reads are combinational.
*/
`timescale 1ns/1ns
module cptd_store #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire logic                     clear,
  input  wire logic                     wr_en,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [W-1:0]             rd_data,
  output logic      [$clog2(DEPTH):0]   count,
  output logic                          full
);
  logic [W-1:0]           mem_ff [DEPTH];
  logic [$clog2(DEPTH):0] cnt_ff;

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("cptd_store needs DEPTH >= 2 and W >= 1");
  end

  assign full    = (cnt_ff == ($clog2(DEPTH) + 1)'(DEPTH));
  assign count   = cnt_ff;
  assign rd_data = mem_ff[rd_idx];

  // Index equals arrival order, so meaning by position is kept
  always_ff @(posedge sys_clk) begin
    if (reset || clear) begin
      cnt_ff <= '0;
    end else if (wr_en && !full) begin
      mem_ff[cnt_ff[$clog2(DEPTH)-1:0]] <= wr_data;
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule

/* File: rtl/cptd_top.sv */
/*
  Decoder for the proprietary template of a card's file control data:
  characteristics, power entries, minimum clocks and free memory.
  Assumes card bytes already in the sys_clk domain and a register master
  that reads data one cycle after the read strobe.
*/
`timescale 1ns/1ns
// Contract
// - Template is tag A5, length, nested objects
// - Same-tag objects consecutive, order kept
// - Characteristics object required for root file
// - Power object only for application directory
// - Minimum clock only for application directory
// - Memory object never for elementary file
// - Report clock stop and preferred level
// - Report supply classes A B C
// - Characteristics b8 and b2 must be zero
// - Power object length three, fields decoded
// - Reference frequency 0.1 MHz, FF none
// - No reference means maximum card clock
// - Minimum clock length one, FF none
// - Keep every power and clock instance; code keeps the first 4 of each and flags later ones as overflow
// - Memory length two plus, MSB first
module cptd_top (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  card_data,
  input  wire logic        card_valid,
  output logic             card_ready,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             done,
  output logic             clk_stop_any,
  output logic             clk_stop_high_ok,
  output logic             clk_stop_low_ok,
  output logic [2:0]       supply_class,
  output logic             min_clk_required
);
  localparam int DEPTH = cptd_pkg::STORE_DEPTH;
  localparam int IW    = $clog2(DEPTH);

  typedef enum logic [2:0] {
    ST_TMPL_TAG, ST_TMPL_LEN, ST_TAG, ST_LEN, ST_VAL, ST_DONE
  } cptd_state_e;

  cptd_strm_if strm ();

  // ==========================================================
  // Registers and state
  cptd_state_e         state_ff;
  logic [7:0]          outer_ff;
  logic [7:0]          len_ff;
  logic [7:0]          idx_ff;
  logic [7:0]          tag_ff;
  logic [7:0]          last_tag_ff;
  logic [3:0]          seen_ff;
  logic                run_ff;
  cptd_pkg::cptd_kind_e kind_ff;
  logic [7:0]          char_ff;
  logic [31:0]         mem_ff;
  logic [15:0]         pwr_hold_ff;
  logic [IW-1:0]       sel_ff;
  logic                chk_ff;
  logic [10:0]         err_ff;
  logic [31:0]         rdata_ff;
  logic                clk_any_ff;
  logic                clk_high_ff;
  logic                clk_low_ff;
  logic [2:0]          class_ff;
  logic                minreq_ff;
  logic [1:0]          pref_ff;

  logic                acc;
  logic                restart;
  logic [7:0]          b;
  logic [7:0]          nxt_outer;
  logic                pwr_wr;
  logic                min_wr;
  logic [22:0]         pwr_rd;
  logic [7:0]          min_rd;
  logic [IW:0]         pwr_cnt;
  logic [IW:0]         min_cnt;
  logic                pwr_full;
  logic                min_full;
  logic                tag_acc;
  logic                len_ok;

  assign restart   = reg_wr && (reg_addr == cptd_pkg::OFS_CTRL)
                     && reg_wdata[cptd_pkg::CTRL_RESTART_BIT];
  assign strm.ready = run_ff && (state_ff != ST_DONE);
  assign acc       = strm.valid && strm.ready;
  assign b         = strm.data;
  assign nxt_outer = outer_ff - 8'h01;
  assign tag_acc   = acc && (state_ff == ST_TAG);

  function automatic logic [3:0] tag_bit(input logic [7:0] t);
    tag_bit = 4'h0;
    case (t)
      cptd_pkg::TAG_CHAR:   tag_bit = 4'h1;
      cptd_pkg::TAG_POWER:  tag_bit = 4'h2;
      cptd_pkg::TAG_MINCLK: tag_bit = 4'h4;
      cptd_pkg::TAG_MEMORY: tag_bit = 4'h8;
      default:              tag_bit = 4'h0;
    endcase
  endfunction

  // Length the current known tag demands
  always_comb begin
    case (tag_ff)
      cptd_pkg::TAG_CHAR:   len_ok = (len_ff == cptd_pkg::LEN_CHAR);
      cptd_pkg::TAG_POWER:  len_ok = (len_ff == cptd_pkg::LEN_POWER);
      cptd_pkg::TAG_MINCLK: len_ok = (len_ff == cptd_pkg::LEN_MINCLK);
      cptd_pkg::TAG_MEMORY: len_ok = (len_ff >= cptd_pkg::LEN_MEM_MIN);
      default:              len_ok = 1'b1;
    endcase
  end

  cptd_skid u_skid (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .in_data  (card_data),
    .in_valid (card_valid),
    .in_ready (card_ready),
    .out      (strm.src)
  );

  // ==========================================================
  // Template walker
  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      state_ff <= ST_TMPL_TAG;
      outer_ff <= 8'h00;
      len_ff   <= 8'h00;
      idx_ff   <= 8'h00;
      tag_ff   <= 8'h00;
    end else if (acc) begin
      case (state_ff)
        ST_TMPL_TAG: state_ff <= (b == cptd_pkg::TAG_TEMPLATE) ? ST_TMPL_LEN : ST_DONE;
        ST_TMPL_LEN: begin
          outer_ff <= b;
          state_ff <= (b == 8'h00) ? ST_DONE : ST_TAG;
        end
        ST_TAG: begin
          tag_ff   <= b;
          outer_ff <= nxt_outer;
          state_ff <= (nxt_outer == 8'h00) ? ST_DONE : ST_LEN;
        end
        ST_LEN: begin
          len_ff   <= b;
          idx_ff   <= 8'h00;
          outer_ff <= nxt_outer;
          // Unknown tags are walked over by their length alone
          if (b > nxt_outer || (b == 8'h00 && nxt_outer == 8'h00)) begin
            state_ff <= ST_DONE;
          end else begin
            state_ff <= (b == 8'h00) ? ST_TAG : ST_VAL;
          end
        end
        ST_VAL: begin
          idx_ff   <= idx_ff + 8'h01;
          outer_ff <= nxt_outer;
          if (idx_ff + 8'h01 == len_ff) begin
            state_ff <= (nxt_outer == 8'h00) ? ST_DONE : ST_TAG;
          end
        end
        default: state_ff <= ST_DONE;
      endcase
    end
  end

  // ==========================================================
  // Value decode
  assign pwr_wr = acc && state_ff == ST_VAL && tag_ff == cptd_pkg::TAG_POWER && len_ok
                  && idx_ff == 8'h02;
  assign min_wr = acc && state_ff == ST_VAL && tag_ff == cptd_pkg::TAG_MINCLK && len_ok;

  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      char_ff     <= cptd_pkg::RST_CHAR;
      mem_ff      <= 32'h0000_0000;
      pwr_hold_ff <= 16'h0000;
    end else if (acc && state_ff == ST_VAL && len_ok) begin
      case (tag_ff)
        cptd_pkg::TAG_CHAR:   char_ff <= b;
        cptd_pkg::TAG_MEMORY: mem_ff  <= {mem_ff[23:0], b};
        cptd_pkg::TAG_POWER: begin
          if (idx_ff == 8'h00) pwr_hold_ff[7:0]  <= b;
          if (idx_ff == 8'h01) pwr_hold_ff[15:8] <= b;
        end
        default: char_ff <= char_ff;
      endcase
    end
  end

  // Clock and supply report straight from the characteristics byte
  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      clk_any_ff  <= 1'b0;
      clk_high_ff <= 1'b0;
      clk_low_ff  <= 1'b0;
      class_ff    <= 3'h0;
      pref_ff     <= 2'h0;
    end else if (acc && state_ff == ST_VAL && len_ok && tag_ff == cptd_pkg::TAG_CHAR) begin
      clk_any_ff  <= b[cptd_pkg::CHAR_STOP_BIT];
      pref_ff     <= b[cptd_pkg::CHAR_LOW_BIT -: 2];
      // Without b1 only the named level is allowed; all zero forbids stopping
      clk_high_ff <= b[cptd_pkg::CHAR_STOP_BIT] | b[cptd_pkg::CHAR_HIGH_BIT];
      clk_low_ff  <= b[cptd_pkg::CHAR_STOP_BIT] | b[cptd_pkg::CHAR_LOW_BIT];
      class_ff    <= b[cptd_pkg::CHAR_CLASS_LSB +: 3];
    end
  end

  // Entry = {no reference, reference freq, current mA, class}; with no
  // reference the current applies at the card's maximum clock
  cptd_store #(.W(23), .DEPTH(DEPTH)) u_pwr (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clear   (restart),
    .wr_en   (pwr_wr),
    .wr_data ({(b == cptd_pkg::FREQ_NONE), b, pwr_hold_ff[13:8], pwr_hold_ff[7:0]}),
    .rd_idx  (sel_ff),
    .rd_data (pwr_rd),
    .count   (pwr_cnt),
    .full    (pwr_full)
  );

  cptd_store #(.W(8), .DEPTH(DEPTH)) u_min (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clear   (restart),
    .wr_en   (min_wr),
    .wr_data (b),
    .rd_idx  (sel_ff),
    .rd_data (min_rd),
    .count   (min_cnt),
    .full    (min_full)
  );

  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      minreq_ff <= 1'b0;
    end else if (min_wr && min_cnt == '0) begin
      minreq_ff <= (b != cptd_pkg::FREQ_NONE);
    end
  end

  // ==========================================================
  // Checks. err: 0 fmt,1 not tmpl,2 order,3 place,4 no char,5 rsv char,
  // 6 rsv power,7 power uninterpretable,8 min range,9 overflow,10 unused
  always_ff @(posedge sys_clk) begin
    if (reset || restart) begin
      err_ff      <= 11'h000;
      seen_ff     <= 4'h0;
      last_tag_ff <= 8'h00;
      chk_ff      <= 1'b0;
    end else begin
      if (acc && state_ff == ST_TMPL_TAG && b != cptd_pkg::TAG_TEMPLATE) err_ff[1] <= 1'b1;
      if (acc && state_ff == ST_LEN && (b > nxt_outer || (b == 8'h00 && tag_bit(tag_ff) != 4'h0)))
        err_ff[0] <= 1'b1;
      if (acc && state_ff == ST_VAL && idx_ff == 8'h00 && !len_ok) err_ff[0] <= 1'b1;
      if (tag_acc && nxt_outer == 8'h00) err_ff[0] <= 1'b1;
      if (tag_acc) begin
        seen_ff     <= seen_ff | tag_bit(b);
        last_tag_ff <= b;
        if ((seen_ff & tag_bit(b)) != 4'h0 && b != last_tag_ff) err_ff[2] <= 1'b1;
        if (b == cptd_pkg::TAG_POWER && kind_ff != cptd_pkg::KIND_APPLICATION_DIRECTORY)
          err_ff[3] <= 1'b1;
        if (b == cptd_pkg::TAG_MINCLK && kind_ff != cptd_pkg::KIND_APPLICATION_DIRECTORY)
          err_ff[3] <= 1'b1;
        if (b == cptd_pkg::TAG_MEMORY && kind_ff == cptd_pkg::KIND_ELEMENTARY_FILE)
          err_ff[3] <= 1'b1;
      end
      if (acc && state_ff == ST_VAL && len_ok && tag_ff == cptd_pkg::TAG_CHAR
          && (b[cptd_pkg::CHAR_RSV_HI] || b[cptd_pkg::CHAR_RSV_LO])) err_ff[5] <= 1'b1;
      if (acc && state_ff == ST_VAL && len_ok && tag_ff == cptd_pkg::TAG_POWER && idx_ff == 8'h01)
      begin
        if (b[7:6] != 2'h0) err_ff[6] <= 1'b1;
        if (b == cptd_pkg::PWR_IGNORE0 || b == cptd_pkg::PWR_IGNORE1 || b > cptd_pkg::PWR_MAX)
          err_ff[7] <= 1'b1;
      end
      if (min_wr && b < cptd_pkg::FREQ_MIN) err_ff[8] <= 1'b1;
      if ((pwr_wr && pwr_full) || (min_wr && min_full)) err_ff[9] <= 1'b1;
      if (state_ff == ST_DONE && !chk_ff) begin
        chk_ff <= 1'b1;
        if (kind_ff == cptd_pkg::KIND_ROOT_MASTER_FILE && !seen_ff[0]) err_ff[4] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Register port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      run_ff  <= cptd_pkg::RST_RUN;
      kind_ff <= cptd_pkg::KIND_ROOT_MASTER_FILE;
      sel_ff  <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        cptd_pkg::OFS_CTRL: begin
          run_ff  <= reg_wdata[cptd_pkg::CTRL_RUN_BIT];
          kind_ff <= cptd_pkg::cptd_kind_e'(reg_wdata[cptd_pkg::CTRL_KIND_LSB +: 2]);
        end
        cptd_pkg::OFS_SELECT: sel_ff <= reg_wdata[IW-1:0];
        default: sel_ff <= sel_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        cptd_pkg::OFS_CTRL:    rdata_ff <= {28'h0, 1'b0, kind_ff, run_ff};
        cptd_pkg::OFS_STATUS:  rdata_ff <= {20'h0, err_ff, chk_ff};
        cptd_pkg::OFS_CHAR:    rdata_ff <= {16'h0, 6'h0, pref_ff, char_ff};
        cptd_pkg::OFS_MEMORY:  rdata_ff <= mem_ff;
        cptd_pkg::OFS_COUNTS:  rdata_ff <= {8'h0, 8'(min_cnt), 8'h0, 8'(pwr_cnt)};
        cptd_pkg::OFS_SELECT:  rdata_ff <= 32'(sel_ff);
        cptd_pkg::OFS_PWR_DAT: rdata_ff <= {9'h0, pwr_rd};
        cptd_pkg::OFS_MIN_DAT: rdata_ff <= {24'h0, min_rd};
        default:               rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata        = rdata_ff;
  assign done             = chk_ff;
  assign clk_stop_any     = clk_any_ff;
  assign clk_stop_high_ok = clk_high_ff;
  assign clk_stop_low_ok  = clk_low_ff;
  assign supply_class     = class_ff;
  assign min_clk_required = minreq_ff;

  // ==========================================================
  // Assertions
  tmpl_tag_a: assert property (@(posedge sys_clk) disable iff (reset)
    acc && state_ff == ST_TMPL_TAG && b != cptd_pkg::TAG_TEMPLATE && !restart
    |=> state_ff == ST_DONE && err_ff[1]) else $error("bad template tag not flagged");
  tag_order_a: assert property (@(posedge sys_clk) disable iff (reset)
    tag_acc && !restart && (seen_ff & tag_bit(b)) != 4'h0 && b != last_tag_ff
    |=> err_ff[2]) else $error("split tag group not flagged");
  char_need_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(chk_ff) && kind_ff == cptd_pkg::KIND_ROOT_MASTER_FILE && !seen_ff[0]
    |-> err_ff[4]) else $error("missing characteristics not flagged");
  power_place_a: assert property (@(posedge sys_clk) disable iff (reset)
    tag_acc && !restart && !reg_wr && b == cptd_pkg::TAG_POWER
    && kind_ff != cptd_pkg::KIND_APPLICATION_DIRECTORY |=> err_ff[3])
    else $error("misplaced power object not flagged");
  minclk_place_a: assert property (@(posedge sys_clk) disable iff (reset)
    tag_acc && !restart && !reg_wr && b == cptd_pkg::TAG_MINCLK
    && kind_ff != cptd_pkg::KIND_APPLICATION_DIRECTORY |=> err_ff[3])
    else $error("misplaced minimum clock not flagged");
  mem_place_a: assert property (@(posedge sys_clk) disable iff (reset)
    tag_acc && !restart && !reg_wr && b == cptd_pkg::TAG_MEMORY
    && kind_ff == cptd_pkg::KIND_ELEMENTARY_FILE |=> err_ff[3])
    else $error("memory object on file not flagged");
  char_decode_a: assert property (@(posedge sys_clk) disable iff (reset)
    acc && !restart && state_ff == ST_VAL && tag_ff == cptd_pkg::TAG_CHAR && len_ok
    |=> clk_stop_any == $past(b[0]) && supply_class == $past(b[6:4])
    && clk_stop_high_ok == ($past(b[0]) | $past(b[2]))) else $error("characteristics decode wrong");
  char_rsv_a: assert property (@(posedge sys_clk) disable iff (reset)
    acc && !restart && state_ff == ST_VAL && tag_ff == cptd_pkg::TAG_CHAR && len_ok
    && (b[7] || b[1]) |=> err_ff[5]) else $error("reserved characteristics bits missed");
  power_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    pwr_wr && !pwr_full && !restart |=> pwr_cnt == $past(pwr_cnt) + 1'b1)
    else $error("power entry not stored");
  minclk_req_a: assert property (@(posedge sys_clk) disable iff (reset)
    min_wr && !restart && min_cnt == '0 |=> min_clk_required == ($past(b) != 8'hff))
    else $error("minimum clock flag wrong");
  mem_shift_a: assert property (@(posedge sys_clk) disable iff (reset)
    acc && !restart && state_ff == ST_VAL && tag_ff == cptd_pkg::TAG_MEMORY && len_ok
    |=> mem_ff == {$past(mem_ff[23:0]), $past(b)}) else $error("memory bytes not MSB first");
endmodule

/* File: sim/cptd_card_model.sv */
/*
  Card side: sends queued response bytes on a valid/ready byte stream.
  Assumes the bench fills q and may set slow for one-cycle gaps.
*/
`timescale 1ns/1ns
module cptd_card_model (
  input  wire logic       sys_clk,
  input  wire logic       card_ready,
  output logic [7:0]      card_data,
  output logic            card_valid
);
  logic [7:0] q[$];
  bit         slow;
  bit         tick;

  initial begin
    card_valid = 1'b0;
    card_data  = 8'h00;
  end

  // ==========================================================
  // Byte source
  // Bytes leave in queue order; a byte is held until taken
  always @(posedge sys_clk) begin
    tick <= ~tick;
    if (!card_valid || card_ready) begin
      // Released line shows the inverse, never a stale byte
      if (card_valid) begin
        card_data <= ~card_data;
      end
      card_valid <= 1'b0;
      if (q.size() != 0 && (!slow || tick)) begin
        card_valid <= 1'b1;
        card_data  <= q.pop_front();
      end
    end
  end
endmodule

/* File: sim/test_cptd_top.sv */
/*
  Self-checking bench for the template decoder.
  Assumes a register master with read data one cycle after the strobe.
*/
`timescale 1ns/1ns
module test_cptd_top;
  logic        sys_clk, reset, card_ready, card_valid, reg_wr, reg_rd, done;
  logic [7:0]  card_data, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic        stop_any, high_ok, low_ok, min_req;
  logic [2:0]  supply;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  cptd_top dut (.sys_clk(sys_clk), .reset(reset), .card_data(card_data),
    .card_valid(card_valid), .card_ready(card_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .done(done), .clk_stop_any(stop_any), .clk_stop_high_ok(high_ok),
    .clk_stop_low_ok(low_ok), .supply_class(supply), .min_clk_required(min_req));
  cptd_card_model card (.sys_clk(sys_clk), .card_ready(card_ready),
    .card_data(card_data), .card_valid(card_valid));

  // ==========================================================
  // Clock, timeout and shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task give_verdict;
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Restart, optionally preload bytes while stalled, run and wait for done
  task run(input logic [1:0] k, input logic [7:0] b[$], input bit pre);
    int n;
    wr(8'h00, {28'h0, 1'b1, k, 1'b0});
    if (pre) begin
      card.q = b;
      repeat (6) @(posedge sys_clk);
      chk("ready", {31'h0, card_ready}, 32'h0);
    end
    wr(8'h00, {29'h0, k, 1'b1});
    if (!pre) card.q = b;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("done", {31'h0, done}, 32'h1);
  endtask

  // ==========================================================
  // Scenarios
  task t_root;
    run(2'd0, '{8'ha5, 8'h08, 8'h80, 8'h01, 8'h75, 8'h83, 8'h03, 8'h01, 8'h02, 8'h03}, 1);
    chk("stop", {29'h0, stop_any, high_ok, low_ok}, 32'h7);
    chk("supply", {29'h0, supply}, 32'h7);
    rd(8'h08); chk("char", rv, 32'h175);
    rd(8'h0c); chk("memory", rv, 32'h10203);
    rd(8'h04); chk("status", rv, 32'h1);
    rd(8'h20); chk("unmapped", rv, 32'h0);
  endtask
  task t_app;
    card.slow = 1'b1;
    run(2'd2, '{8'ha5, 8'h13, 8'h81, 8'h03, 8'h01, 8'h3c, 8'h0a, 8'h81, 8'h03, 8'h02,
      8'h05, 8'hff, 8'h82, 8'h01, 8'hff, 8'h82, 8'h01, 8'h20, 8'h85, 8'h01, 8'haa}, 0);
    card.slow = 1'b0;
    rd(8'h10); chk("counts", rv, 32'h20002);
    wr(8'h14, 32'h0);
    rd(8'h18); chk("power0", rv, 32'h2bc01);
    wr(8'h14, 32'h1);
    rd(8'h18); chk("power1", rv, 32'h7fc502);
    rd(8'h1c); chk("minclk1", rv, 32'h20);
    chk("minreq", {31'h0, min_req}, 32'h0);
    chk("stop", {29'h0, stop_any, high_ok, low_ok}, 32'h0);
    rd(8'h04); chk("status", rv, 32'h1);
  endtask
  task t_ef;
    run(2'd3, '{8'ha5, 8'h09, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0a, 8'h83, 8'h02, 8'h00, 8'h01}, 0);
    rd(8'h04); chk("status", rv, 32'h111);
  endtask
  task t_rsv;
    run(2'd0, '{8'ha5, 8'h07, 8'h80, 8'h01, 8'h83, 8'h83, 8'h02, 8'h12, 8'h34}, 0);
    rd(8'h04); chk("status", rv, 32'h41);
    rd(8'h0c); chk("memory", rv, 32'h1234);
    chk("stop", {29'h0, stop_any, high_ok, low_ok}, 32'h7);
  endtask
  // Directory: high-only stop, minimum clock present, empty unknown object last
  task t_dir;
    run(2'd1, '{8'ha5, 8'h08, 8'h80, 8'h01, 8'h04, 8'h82, 8'h01, 8'h05, 8'h85, 8'h00}, 0);
    chk("stop", {29'h0, stop_any, high_ok, low_ok}, 32'h2);
    chk("supply", {29'h0, supply}, 32'h0);
    chk("minreq", {31'h0, min_req}, 32'h1);
    rd(8'h04); chk("status", rv, 32'h211);
  endtask

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_root();
    t_app();
    t_ef();
    t_rsv();
    t_dir();
    give_verdict();
  end
endmodule
